// [pkg/pq_reserve_defs.vh]
// register offsets, field positions, command codes and reset values for the packet queue block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef PQ_RESERVE_DEFS_VH
`define PQ_RESERVE_DEFS_VH

`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_SELECT    8'h08
`define OFS_RESERVE   8'h0C
`define OFS_FREE      8'h10
`define OFS_SIZE      8'h14
`define OFS_STATUS    8'h18
`define OFS_MASK      8'h1C
`define OFS_RESULT    8'h20
`define OFS_RXPORT    8'h24
`define OFS_TXPORT    8'h28

`define CTRL_TXALLOW  0
`define CTRL_AUTOFREE 1

`define CMD_ALLOC     3'h1
`define CMD_ENQUEUE   3'h2
`define CMD_RELEASE   3'h3
`define CMD_RXPOP     3'h4
`define CMD_TXACK     3'h5

`define FLG_RX        0
`define FLG_TXDONE    1
`define FLG_DRAINED   2
`define FLG_GRANT     3

`define MASK_RESET    4'h0
`define RESV_RESET    8'h00

`endif

// [design/packet_queue_reserve_and_irq.v]
// page allocator with transmit reserve, three packet queues and interrupt flags
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pq_reserve_defs.vh"

module packet_queue_reserve_and_irq #(
    parameter NUM_PKTS = 16,
    parameter NW       = 4
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rxAllocReq,
    input  wire        rxInProgress,
    input  wire        rxEnd,
    input  wire        rxCrcOk,
    output reg         rxAllocGrant,
    output reg         rxAllocFail,
    output reg  [NW-1:0] rxPktNum,
    output reg         txStart,
    output reg  [NW-1:0] txPktNum,
    input  wire        txDone,
    input  wire        txOk,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    reg [NUM_PKTS-1:0] used_q;
    reg [NW-1:0] rxq [0:NUM_PKTS-1];
    reg [NW-1:0] txq [0:NUM_PKTS-1];
    reg [NW-1:0] cq  [0:NUM_PKTS-1];
    reg [NW:0]   rxCnt_q, txCnt_q, cCnt_q;
    reg [NW-1:0] rxHd_q, txHd_q, cHd_q;
    reg [1:0]    ctrl_q;
    reg [7:0]    resv_q;
    reg [3:0]    mask_q;
    reg [3:0]    flag_q;
    reg [NW-1:0] select_q;
    reg [NW-1:0] result_q;
    reg          resFail_q;
    reg          busy_q;
    reg [NW-1:0] rxCur_q;
    reg          rxHave_q;
    reg          allocPend_q;
    reg [7:0]    awAddr_q;
    reg          awHave_q;
    reg [31:0]   wData_q;
    reg          wHave_q;
    integer      i;

    // first free page, lowest index wins
    function [NW:0] firstFree;
        input [NUM_PKTS-1:0] u;
        integer k;
        begin
            firstFree = {1'b1, {NW{1'b0}}};
            for (k = NUM_PKTS - 1; k >= 0; k = k - 1) begin
                if (!u[k]) begin
                    firstFree = {1'b0, k[NW-1:0]};
                end
            end
        end
    endfunction

    function [7:0] popCount;
        input [NUM_PKTS-1:0] u;
        integer k;
        begin
            popCount = 8'h00;
            for (k = 0; k < NUM_PKTS; k = k + 1) begin
                popCount = popCount + {7'h00, ~u[k]};
            end
        end
    endfunction

    wire [7:0] freeCnt = popCount(used_q);
    wire [NW:0] ff = firstFree(used_q);
    wire        haveFree = ~ff[NW];

    // ------------------------------------------------------------------------
    // axi write capture
    // ------------------------------------------------------------------------
    wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    wire doRead  = s_axi_arvalid && s_axi_arready;
    wire [2:0] cmd = wData_q[2:0];
    wire wrCmd  = doWrite && awAddr_q == `OFS_CMD;
    wire hAlloc = wrCmd && cmd == `CMD_ALLOC;
    wire hEnq   = wrCmd && cmd == `CMD_ENQUEUE;
    wire hRel   = wrCmd && cmd == `CMD_RELEASE;
    wire hRxPop = wrCmd && cmd == `CMD_RXPOP && rxCnt_q != 0;
    wire hTxAck = wrCmd && cmd == `CMD_TXACK && cCnt_q != 0;

    // host allocation: one page per request, served in a cycle with no receive grant
    // receive wins over a pending host request in the same cycle
    wire rxTry  = rxAllocReq && !rxHave_q;
    wire rxOk   = haveFree && (freeCnt > resv_q);
    wire rxGo   = rxTry && rxOk;
    wire hGo    = allocPend_q && !rxGo && haveFree;
    // transmit engine: start next queued packet without host involvement
    wire txIss  = ctrl_q[`CTRL_TXALLOW] && !busy_q && txCnt_q != 0;
    wire fin    = busy_q && txDone;
    wire autoF  = fin && txOk && ctrl_q[`CTRL_AUTOFREE];
    wire cPush  = fin && !autoF;
    wire rxPush = rxEnd && rxHave_q && rxCrcOk;
    wire rxDrop = rxEnd && rxHave_q && !rxCrcOk;

    // ------------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            awHave_q      <= 1'b0;
            wHave_q       <= 1'b0;
            awAddr_q      <= 8'h00;
            wData_q       <= 32'h0000_0000;
        end else begin
            s_axi_awready <= !awHave_q && !s_axi_awready;
            s_axi_wready  <= !wHave_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q[1:0] != 2'b00 || awAddr_q > `OFS_TXPORT) ?
                                2'b10 : 2'b00;
                awHave_q     <= 1'b0;
                wHave_q      <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > `OFS_TXPORT) ?
                                2'b10 : 2'b00;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // read data mux; queue ports show head entries
    // free and size read-only
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rdata <= 32'h0000_0000;
        end else if (doRead) begin
            case (s_axi_araddr)
                `OFS_CTRL:    s_axi_rdata <= {30'h0, ctrl_q};
                `OFS_SELECT:  s_axi_rdata <= {{(32-NW){1'b0}}, select_q};
                `OFS_RESERVE: s_axi_rdata <= {24'h00_0000, resv_q};
                `OFS_FREE:    s_axi_rdata <= {24'h00_0000, freeCnt};
                `OFS_SIZE:    s_axi_rdata <= NUM_PKTS;
                `OFS_STATUS:  s_axi_rdata <= {27'h0, busy_q, flag_q};
                `OFS_MASK:    s_axi_rdata <= {28'h0, mask_q};
                `OFS_RESULT:  s_axi_rdata <= {resFail_q, {(31-NW){1'b0}}, result_q};
                `OFS_RXPORT:  s_axi_rdata <= {(rxCnt_q == 0), {(31-NW){1'b0}},
                                              rxq[rxHd_q]};
                `OFS_TXPORT:  s_axi_rdata <= {(cCnt_q == 0), {(31-NW){1'b0}},
                                              cq[cHd_q]};
                default:      s_axi_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= 2'b00;
            resv_q   <= `RESV_RESET;
            mask_q   <= `MASK_RESET;
            select_q <= {NW{1'b0}};
        end else begin
            if (doWrite && awAddr_q == `OFS_CTRL && s_axi_wstrb[0]) begin
                ctrl_q <= wData_q[1:0];
            end else if (fin && !txOk) begin
                ctrl_q[`CTRL_TXALLOW] <= 1'b0;
            end
            if (doWrite && awAddr_q == `OFS_RESERVE && s_axi_wstrb[0]) begin
                resv_q <= wData_q[7:0];
            end
            if (doWrite && awAddr_q == `OFS_MASK && s_axi_wstrb[0]) begin
                mask_q <= wData_q[3:0];
            end
            if (doWrite && awAddr_q == `OFS_SELECT && s_axi_wstrb[0]) begin
                select_q <= wData_q[NW-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // page pool and receive allocation
    // ------------------------------------------------------------------------
    // shared pool, two requesters
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            used_q       <= {NUM_PKTS{1'b0}};
            rxHave_q     <= 1'b0;
            rxCur_q      <= {NW{1'b0}};
            rxAllocGrant <= 1'b0;
            rxAllocFail  <= 1'b0;
            rxPktNum     <= {NW{1'b0}};
            allocPend_q  <= 1'b0;
            result_q     <= {NW{1'b0}};
            resFail_q    <= 1'b0;
        end else begin
            rxAllocGrant <= rxGo;
            // fail lifts when frees raise count
            rxAllocFail  <= rxTry && !rxOk;
            if (rxGo) begin
                used_q[ff[NW-1:0]] <= 1'b1;
                rxHave_q <= 1'b1;
                rxCur_q  <= ff[NW-1:0];
                rxPktNum <= ff[NW-1:0];
            end
            if (hAlloc) begin
                allocPend_q <= 1'b1;
                resFail_q   <= 1'b1;
            end else if (hGo) begin
                allocPend_q <= 1'b0;
                used_q[ff[NW-1:0]] <= 1'b1;
                result_q  <= ff[NW-1:0];
                resFail_q <= 1'b0;
            end
            if (rxDrop) begin
                used_q[rxCur_q] <= 1'b0;
            end
            if (rxEnd) begin
                rxHave_q <= 1'b0;
            end
            if (hRel) begin
                used_q[select_q] <= 1'b0;
            end
            if (hRxPop) begin
                used_q[rxq[rxHd_q]] <= 1'b0;
            end
            if (autoF) begin
                used_q[txPktNum] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // queues and transmit sequencing
    // ------------------------------------------------------------------------
    // engine advances without register reads
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCnt_q  <= {(NW+1){1'b0}};
            txCnt_q  <= {(NW+1){1'b0}};
            cCnt_q   <= {(NW+1){1'b0}};
            rxHd_q   <= {NW{1'b0}};
            txHd_q   <= {NW{1'b0}};
            cHd_q    <= {NW{1'b0}};
            busy_q   <= 1'b0;
            txStart  <= 1'b0;
            txPktNum <= {NW{1'b0}};
            for (i = 0; i < NUM_PKTS; i = i + 1) begin
                rxq[i] <= {NW{1'b0}};
                txq[i] <= {NW{1'b0}};
                cq[i]  <= {NW{1'b0}};
            end
        end else begin
            txStart <= txIss;
            if (rxPush) begin
                rxq[rxHd_q + rxCnt_q[NW-1:0]] <= rxCur_q;
            end
            if (rxPush && !hRxPop) begin
                rxCnt_q <= rxCnt_q + 1'b1;
            end else if (!rxPush && hRxPop) begin
                rxCnt_q <= rxCnt_q - 1'b1;
            end
            if (hRxPop) begin
                rxHd_q <= rxHd_q + 1'b1;
            end
            if (hEnq) begin
                txq[txHd_q + txCnt_q[NW-1:0]] <= select_q;
            end
            if (hEnq && !txIss) begin
                txCnt_q <= txCnt_q + 1'b1;
            end else if (!hEnq && txIss) begin
                txCnt_q <= txCnt_q - 1'b1;
            end
            if (txIss) begin
                txHd_q   <= txHd_q + 1'b1;
                txPktNum <= txq[txHd_q];
                busy_q   <= 1'b1;
            end else if (fin) begin
                busy_q <= 1'b0;
            end
            if (cPush) begin
                cq[cHd_q + cCnt_q[NW-1:0]] <= txPktNum;
            end
            if (cPush && !hTxAck) begin
                cCnt_q <= cCnt_q + 1'b1;
            end else if (!cPush && hTxAck) begin
                cCnt_q <= cCnt_q - 1'b1;
            end
            if (hTxAck) begin
                cHd_q <= cHd_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // flags and interrupt
    // ------------------------------------------------------------------------
    wire rxNext   = (rxCnt_q != 0 || rxPush) && !(rxCnt_q == 1 && hRxPop && !rxPush);
    wire cNext    = (cCnt_q != 0 || cPush) && !(cCnt_q == 1 && hTxAck && !cPush);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 4'h0;
            irq    <= 1'b0;
        end else begin
            flag_q[`FLG_RX] <= rxNext;
            flag_q[`FLG_TXDONE] <= cNext;
            flag_q[`FLG_DRAINED] <= txCnt_q == 0 && !busy_q && !hEnq;
            // cleared on request, set on grant
            if (hAlloc) begin
                flag_q[`FLG_GRANT] <= 1'b0;
            end else if (hGo) begin
                flag_q[`FLG_GRANT] <= 1'b1;
            end
            irq <= |(flag_q & mask_q);
        end
    end

endmodule
`default_nettype wire

// [verification/pq_reserve_checker_sva.sv]
// port-level timing checker for the packet queue block
`timescale 1ns/10ps
`default_nettype none
`include "pq_reserve_defs.vh"
module pq_reserve_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       rxAllocReq,
    input wire logic       rxAllocGrant,
    input wire logic       rxAllocFail,
    input wire logic       txStart,
    input wire logic       irq
);
    // ------------------------------------------------------------
    // helper state and assertions
    // ------------------------------------------------------------
    logic maskSeen_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // mask resets to zero, so irq must stay low until it is written
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            maskSeen_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OFS_MASK) begin
            maskSeen_q <= 1'b1;
        end
    end
    AST_RX_ANSWER: assert property ($rose(rxAllocReq) |=> rxAllocGrant ^ rxAllocFail)
        else $error("rx page request not answered next cycle");
    AST_RX_EXCL: assert property (!(rxAllocGrant && rxAllocFail))
        else $error("rx grant and refusal together");
    AST_RX_CAUSE: assert property ((rxAllocGrant || rxAllocFail) |-> $past(rxAllocReq))
        else $error("rx answer without request");
    AST_TX_SPACING: assert property (txStart |=> (!txStart)[*2])
        else $error("second tx start while busy");
    AST_IRQ_MASKED: assert property (!maskSeen_q |-> !irq)
        else $error("irq high with reset mask");
    AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
endmodule
bind packet_queue_reserve_and_irq pq_reserve_checker u_pq_reserve_checker (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rxAllocReq(rxAllocReq), .rxAllocGrant(rxAllocGrant),
    .rxAllocFail(rxAllocFail), .txStart(txStart), .irq(irq));
`default_nettype wire

// [verification/tx_mac_model.sv]
// transmit line model: each start is answered by a done pulse after a lag
`timescale 1ns/10ps
`default_nettype none
module tx_mac_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       txStart,
    input  wire logic       failNext,
    input  wire logic [3:0] lag,
    output logic            txDone,
    output logic            txOk
);
    logic [3:0] count_q;
    logic       busy_q;
    // txOk toggles outside done so a stale value is never trusted
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 4'h0;
            busy_q <= 1'b0;
            txDone <= 1'b0;
            txOk <= 1'b0;
        end else begin
            txDone <= 1'b0;
            txOk <= ~txOk;
            if (txStart) begin
                busy_q <= 1'b1;
                count_q <= lag;
            end else if (busy_q && count_q != 4'h0) begin
                count_q <= count_q - 4'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                txDone <= 1'b1;
                txOk <= ~failNext;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/packet_queue_reserve_and_irq_test.sv]
// self-checking bench for the packet queue reserve and interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "pq_reserve_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module packet_queue_reserve_and_irq_test;
    localparam int NP = 16;
    logic        core_clk = 0, rst_n = 0, g, failNext = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 0, rxPktNum, txPktNum, lag = 0, pa, pb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, rxAllocReq = 0, rxInProgress = 0, rxEnd = 0, rxCrcOk = 0;
    logic        rxAllocGrant, rxAllocFail, txStart, txDone, txOk, irq;
    int          n_mismatch = 0, checks = 0, cyc = 0, cnt, resv;
    always #12.5 core_clk = ~core_clk;
    packet_queue_reserve_and_irq #(.NUM_PKTS(NP), .NW(4)) u_packet_queue_reserve_and_irq (
        .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rxAllocReq(rxAllocReq), .rxInProgress(rxInProgress),
        .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .rxAllocGrant(rxAllocGrant), .rxAllocFail(rxAllocFail),
        .rxPktNum(rxPktNum), .txStart(txStart), .txPktNum(txPktNum), .txDone(txDone),
        .txOk(txOk), .irq(irq));
    tx_mac_model u_tx_mac_model (.core_clk(core_clk), .rst_n(rst_n), .txStart(txStart),
        .failNext(failNext), .lag(lag), .txDone(txDone), .txOk(txOk));
    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            close_out();
        end
    end
    // with reserve r, pages are granted while free stays above r
    function automatic int expGrants(input int r);
        return NP - r;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && wd)) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1 && !ad) begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wready === 1'b1 && !wd) begin
                wd = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input string nm);
        rd(a);
        `CHK(nm, e, rv & m)
    endtask
    // poll a field; a hang is cut by the guard above
    task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
        do rd(a); while ((rv & m) !== e);
    endtask
    // one received frame: request a page, then end it with the given crc if the page was granted
    task automatic rxPkt(input logic crc);
        @(posedge core_clk);
        rxAllocReq <= 1;
        rxInProgress <= 1;
        do @(posedge core_clk); while ((rxAllocGrant | rxAllocFail) !== 1'b1);
        g = rxAllocGrant;
        rxAllocReq <= 0;
        rxEnd <= g;
        rxCrcOk <= crc;
        @(posedge core_clk);
        rxEnd <= 0;
        rxInProgress <= 0;
        rxCrcOk <= ~crc;
    endtask
    task automatic txSend(output logic [3:0] n);
        wr(`OFS_CMD, `CMD_ALLOC);
        rdchk(`OFS_STATUS, 32'h0000_0008, 32'h0000_0008, "grant flag");
        rd(`OFS_RESULT);
        `CHK("alloc ok", 1'b0, rv[31])
        n = rv[3:0];
        wr(`OFS_SELECT, {28'h000_0000, n});
        lag <= 4'($urandom % 8);
        wr(`OFS_CMD, `CMD_ENQUEUE);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(68480));
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        rdchk(`OFS_SIZE, '1, NP, "size");
        rdchk(`OFS_RESERVE, '1, 0, "reserve");
        rdchk(`OFS_MASK, '1, 0, "mask");
        wr(`OFS_FREE, 32'h0000_0003);
        `CHK("ro wresp", 2'b00, rr)
        wr(8'h40, 32'h0000_0001);
        `CHK("unmapped wresp", 2'b10, rr)
        rdchk(`OFS_FREE, '1, NP, "free ro");
        rd(8'h40);
        `CHK("unmapped resp", 2'b10, rr)
        `CHK("unmapped data", 32'h0000_0000, rv)
        $display("test registers done");
        // fill at reserve zero, then at a random reserve
        for (int k = 0; k < 2; k++) begin
            resv = (k == 0) ? 0 : 1 + $urandom % 6;
            wr(`OFS_RESERVE, resv);
            cnt = 0;
            g = 1;
            while (g) begin
                rxPkt(1);
                if (cnt == 0) pa = rxPktNum;
                cnt += int'(g);
            end
            `CHK("rx grants", expGrants(resv), cnt)
            rdchk(`OFS_RXPORT, 32'h8000_000f, pa, "rx head");
            rdchk(`OFS_FREE, '1, resv, "free at refusal");
            wr(`OFS_MASK, 1);
            rdchk(`OFS_STATUS, 1, 1, "rx flag");
            `CHK("irq rx", 1'b1, irq)
            if (k == 1) begin
                wr(`OFS_RESERVE, NP);
                wr(`OFS_CMD, `CMD_RXPOP);
                cnt--;
                rxPkt(1);
                `CHK("rx refused", 1'b0, g)
                wr(`OFS_RESERVE, resv);
                rxPkt(1);
                `CHK("rx resumed", 1'b1, g)
                cnt += int'(g);
            end
            repeat (cnt) wr(`OFS_CMD, `CMD_RXPOP);
            rdchk(`OFS_FREE, '1, NP, "free drained");
            `CHK("irq idle", 1'b0, irq)
            wr(`OFS_MASK, 0);
            $display("test reserve %0d done", resv);
        end
        rxPkt(0);
        rdchk(`OFS_FREE, '1, NP, "free bad crc");
        rdchk(`OFS_STATUS, 1, 0, "rx flag bad crc");
        $display("test bad crc done");
        // two packets back to back, host reads completions in order
        wr(`OFS_CTRL, 1);
        txSend(pa);
        txSend(pb);
        poll(`OFS_TXPORT, 32'h8000_0000, 0);
        `CHK("first done", pa, rv[3:0])
        rdchk(`OFS_STATUS, 2, 2, "tx done flag");
        wr(`OFS_CMD, `CMD_TXACK);
        poll(`OFS_TXPORT, 32'h8000_0000, 0);
        `CHK("second done", pb, rv[3:0])
        `CHK("tx num", pb, txPktNum)
        wr(`OFS_CMD, `CMD_TXACK);
        wr(`OFS_MASK, 4);
        rdchk(`OFS_STATUS, 6, 4, "drained");
        `CHK("irq drained", 1'b1, irq)
        rdchk(`OFS_FREE, '1, NP - 2, "pages held");
        for (int j = 0; j < 2; j++) begin
            wr(`OFS_SELECT, j ? pb : pa);
            wr(`OFS_CMD, `CMD_RELEASE);
        end
        $display("test tx queue done");
        // free on success, then a failed frame under the same setting
        wr(`OFS_CTRL, 3);
        txSend(pa);
        poll(`OFS_FREE, '1, NP);
        rdchk(`OFS_TXPORT, 32'h8000_0000, 32'h8000_0000, "no entry");
        failNext <= 1;
        txSend(pb);
        poll(`OFS_STATUS, 2, 2);
        rdchk(`OFS_TXPORT, 32'h8000_000f, pb, "failed num");
        rdchk(`OFS_CTRL, 1, 0, "allow cleared");
        wr(`OFS_MASK, 2);
        rdchk(`OFS_STATUS, 2, 2, "fatal done");
        `CHK("irq tx", 1'b1, irq)
        failNext <= 0;
        // interrupted loader had some page selected
        resv = $urandom % NP;
        wr(`OFS_SELECT, resv);
        rd(`OFS_SELECT);
        pa = rv[3:0];
        wr(`OFS_SELECT, pb);
        wr(`OFS_CMD, `CMD_TXACK);
        wr(`OFS_CMD, `CMD_RELEASE);
        wr(`OFS_SELECT, pa);
        rdchk(`OFS_SELECT, '1, resv, "select restored");
        rdchk(`OFS_FREE, '1, NP, "free after fail");
        $display("test auto free done");
        close_out();
    end
endmodule
`default_nettype wire
